// [rtl/ipr_input_remap.v]
// Input pin remap selectors with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "ipr_regs.vh"

module ipr_input_remap #(
  parameter NUM_PINS = 26
) (
  input  wire                ref_clk,                // System clock, 100 MHz
  input  wire                rst_n,                  // Synchronous reset, active low
  input  wire                psel,                   // APB select
  input  wire                penable,                // APB access phase
  input  wire                pwrite,                 // APB direction, high for write
  input  wire [11:0]         paddr,                  // APB byte address
  input  wire [31:0]         pwdata,                 // APB write data
  output reg  [31:0]         prdata,                 // APB read data
  output reg                 pready,                 // APB ready
  output reg                 pslverr,                // APB error, unmapped address
  input  wire [NUM_PINS-1:0] remappable_pin_n,       // Remappable pin levels
  output reg                 remap_write_lock,       // Lock bit, one clock behind the lock register
  output reg                 compare_fault_a_input,  // Routed compare fault A
  output reg                 uart_one_clear_to_send, // Routed UART one CTS
  output reg                 uart_one_receive_in,    // Routed UART one RX
  output reg                 uart_two_clear_to_send, // Routed UART two CTS
  output reg                 uart_two_receive_in,    // Routed UART two RX
  output reg                 spi_one_clock_in,       // Routed SPI one clock
  output reg                 spi_one_data_in,        // Routed SPI one data
  output reg                 spi_one_slave_select_in,// Routed SPI one select
  output reg                 spi_two_clock_in,       // Routed SPI two clock
  output reg                 spi_two_data_in,        // Routed SPI two data
  output reg                 spi_two_slave_select_in // Routed SPI two select
);

  localparam NSEL = 11;
  localparam W    = `IPR_SEL_W;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, one aligned word each, fields in the low half
  //
  //   0x00  fault A        bits 4:0
  //   0x04  UART one       CTS 12:8, receive 4:0
  //   0x08  UART two       CTS 12:8, receive 4:0
  //   0x0C  SPI one        clock 12:8, data 4:0
  //   0x10  SPI one        slave select 4:0
  //   0x14  SPI two        clock 12:8, data 4:0
  //   0x18  SPI two        slave select 4:0
  //   0x1C  lock           bit 0
  //   Other bits read zero, other addresses answer with an error
  //
  // Slots of the packed selector word, W bits each
  //
  //   0  fault A           1  UART one receive   2  UART one CTS
  //   3  UART two receive  4  UART two CTS       5  SPI one data
  //   6  SPI one clock     7  SPI one select     8  SPI two data
  //   9  SPI two clock     10 SPI two select
  //
  // Selector codes
  //
  //   0 to 25   pin of that number
  //   26 to 30  undefined, taken as ground
  //   31        ground, the reset value

  ////////////////////////////////////////////////////////////////////////////
  // Selector storage

  reg  [W*NSEL-1:0] sel_q;
  reg  [W*NSEL-1:0] sel_d;
  reg               lock_q;
  reg               lock_d;
  wire [NSEL-1:0]   routed;
  wire [W-1:0]      fault_a_pin_choice       = sel_q[0*W +: W];
  wire [W-1:0]      uart_one_rx_pin_choice   = sel_q[1*W +: W];
  wire [W-1:0]      uart_one_cts_pin_choice  = sel_q[2*W +: W];
  wire [W-1:0]      uart_two_rx_pin_choice   = sel_q[3*W +: W];
  wire [W-1:0]      uart_two_cts_pin_choice  = sel_q[4*W +: W];
  wire [W-1:0]      spi_one_data_pin_choice  = sel_q[5*W +: W];
  wire [W-1:0]      spi_one_clock_pin_choice = sel_q[6*W +: W];
  wire [W-1:0]      spi_one_select_pin_choice= sel_q[7*W +: W];
  wire [W-1:0]      spi_two_data_pin_choice  = sel_q[8*W +: W];
  wire [W-1:0]      spi_two_clock_pin_choice = sel_q[9*W +: W];
  wire [W-1:0]      spi_two_select_pin_choice= sel_q[10*W +: W];

  wire        wr_en  = psel & penable & pwrite & ~pready;
  wire        sel_wr = wr_en & ~lock_q;
  wire [W-1:0] wlo   = pwdata[`IPR_LO_MSB:`IPR_LO_LSB];
  wire [W-1:0] whi   = pwdata[`IPR_HI_MSB:`IPR_HI_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and write strobes

  wire hit_fault_a    = (paddr == `IPR_ADDR_FAULT_A);
  wire hit_uart_one   = (paddr == `IPR_ADDR_UART_ONE);
  wire hit_uart_two   = (paddr == `IPR_ADDR_UART_TWO);
  wire hit_spi_one_cd = (paddr == `IPR_ADDR_SPI_ONE_CD);
  wire hit_spi_one_ss = (paddr == `IPR_ADDR_SPI_ONE_SS);
  wire hit_spi_two_cd = (paddr == `IPR_ADDR_SPI_TWO_CD);
  wire hit_spi_two_ss = (paddr == `IPR_ADDR_SPI_TWO_SS);
  wire hit_lock       = (paddr == `IPR_ADDR_LOCK);
  // Unaligned or unused addresses fall out here
  wire hit_any        = hit_fault_a | hit_uart_one | hit_uart_two |
                        hit_spi_one_cd | hit_spi_one_ss |
                        hit_spi_two_cd | hit_spi_two_ss | hit_lock;

  // Lock register stays writable so software can always unlock
  wire wr_lock        = wr_en & hit_lock;
  // Selector strobes are blocked while locked
  wire wr_fault_a     = sel_wr & hit_fault_a;
  wire wr_uart_one    = sel_wr & hit_uart_one;
  wire wr_uart_two    = sel_wr & hit_uart_two;
  wire wr_spi_one_cd  = sel_wr & hit_spi_one_cd;
  wire wr_spi_one_ss  = sel_wr & hit_spi_one_ss;
  wire wr_spi_two_cd  = sel_wr & hit_spi_two_cd;
  wire wr_spi_two_ss  = sel_wr & hit_spi_two_ss;

  always @* begin
    sel_d  = sel_q;
    lock_d = lock_q;
    if (wr_lock) begin
      lock_d = pwdata[`IPR_LOCK_BIT];
    end
    // Only field bits are stored, others are dropped
    if (wr_fault_a) begin
      sel_d[0*W +: W] = wlo;
    end
    if (wr_uart_one) begin
      sel_d[1*W +: W] = wlo;
      sel_d[2*W +: W] = whi;
    end
    if (wr_uart_two) begin
      sel_d[3*W +: W] = wlo;
      sel_d[4*W +: W] = whi;
    end
    if (wr_spi_one_cd) begin
      sel_d[5*W +: W] = wlo;
      sel_d[6*W +: W] = whi;
    end
    if (wr_spi_one_ss) begin
      sel_d[7*W +: W] = wlo;
    end
    if (wr_spi_two_cd) begin
      sel_d[8*W +: W] = wlo;
      sel_d[9*W +: W] = whi;
    end
    if (wr_spi_two_ss) begin
      sel_d[10*W +: W] = wlo;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sel_q  <= {NSEL{`IPR_SEL_RESET}};
      lock_q <= 1'b0;
    end else begin
      sel_q  <= sel_d;
      lock_q <= lock_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Independent pin multiplexers

  // Several inputs may share one pin; each slot has its own mux
  // Pins at or above NUM_PINS are treated as ground
  genvar g;
  generate
    for (g = 0; g < NSEL; g = g + 1) begin : g_mux
      wire [W-1:0] code     = sel_q[g*W +: W];
      // Codes above the last pin, 11111 included, give ground
      wire         in_range = (code <= `IPR_SEL_MAXPIN) && (code < NUM_PINS);
      wire         pin_lvl  = in_range ? remappable_pin_n[code] : 1'b0;
      assign routed[g] = pin_lvl;
    end
  endgenerate

  // One flop per routed input, reset low
  // Compare fault A
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      compare_fault_a_input <= 1'b0;
    end else begin
      compare_fault_a_input <= routed[0];
    end
  end

  // UART one receive
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      uart_one_receive_in <= 1'b0;
    end else begin
      uart_one_receive_in <= routed[1];
    end
  end

  // UART one clear to send
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      uart_one_clear_to_send <= 1'b0;
    end else begin
      uart_one_clear_to_send <= routed[2];
    end
  end

  // UART two receive
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      uart_two_receive_in <= 1'b0;
    end else begin
      uart_two_receive_in <= routed[3];
    end
  end

  // UART two clear to send
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      uart_two_clear_to_send <= 1'b0;
    end else begin
      uart_two_clear_to_send <= routed[4];
    end
  end

  // SPI one data
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      spi_one_data_in <= 1'b0;
    end else begin
      spi_one_data_in <= routed[5];
    end
  end

  // SPI one clock
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      spi_one_clock_in <= 1'b0;
    end else begin
      spi_one_clock_in <= routed[6];
    end
  end

  // SPI one slave select
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      spi_one_slave_select_in <= 1'b0;
    end else begin
      spi_one_slave_select_in <= routed[7];
    end
  end

  // SPI two data
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      spi_two_data_in <= 1'b0;
    end else begin
      spi_two_data_in <= routed[8];
    end
  end

  // SPI two clock
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      spi_two_clock_in <= 1'b0;
    end else begin
      spi_two_clock_in <= routed[9];
    end
  end

  // SPI two slave select
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      spi_two_slave_select_in <= 1'b0;
    end else begin
      spi_two_slave_select_in <= routed[10];
    end
  end

  // Lock copy, one clock behind the lock register
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      remap_write_lock <= 1'b0;
    end else begin
      remap_write_lock <= lock_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer in the second access cycle
  //
  //   Setup cycle   psel high, penable low
  //   Access cycle  penable high, write stored at its closing edge
  //   Answer cycle  pready high with read data or error
  //   Next setup may follow straight after the answer
  //   Locked selector writes end normally, no error

  reg [31:0] rd_d;
  reg        bad_d;

  // Read words, unused bits tied to zero
  wire [31:0] rd_fault_a  = {27'h0000000, fault_a_pin_choice};
  wire [31:0] rd_uart_one = {19'h00000, uart_one_cts_pin_choice, 3'h0,
                             uart_one_rx_pin_choice};
  wire [31:0] rd_uart_two = {19'h00000, uart_two_cts_pin_choice, 3'h0,
                             uart_two_rx_pin_choice};
  wire [31:0] rd_spi_one  = {19'h00000, spi_one_clock_pin_choice, 3'h0,
                             spi_one_data_pin_choice};
  wire [31:0] rd_spi_one_ss = {27'h0000000, spi_one_select_pin_choice};
  wire [31:0] rd_spi_two  = {19'h00000, spi_two_clock_pin_choice, 3'h0,
                             spi_two_data_pin_choice};
  wire [31:0] rd_spi_two_ss = {27'h0000000, spi_two_select_pin_choice};
  wire [31:0] rd_lock     = {31'h00000000, lock_q};

  always @* begin
    rd_d  = 32'h0000_0000;
    bad_d = ~hit_any;
    case (paddr)
      `IPR_ADDR_FAULT_A:    rd_d = rd_fault_a;
      `IPR_ADDR_UART_ONE:   rd_d = rd_uart_one;
      `IPR_ADDR_UART_TWO:   rd_d = rd_uart_two;
      `IPR_ADDR_SPI_ONE_CD: rd_d = rd_spi_one;
      `IPR_ADDR_SPI_ONE_SS: rd_d = rd_spi_one_ss;
      `IPR_ADDR_SPI_TWO_CD: rd_d = rd_spi_two;
      `IPR_ADDR_SPI_TWO_SS: rd_d = rd_spi_two_ss;
      `IPR_ADDR_LOCK:       rd_d = rd_lock;
      default:              rd_d = 32'h0000_0000;
    endcase
  end

  // Access taken when the access phase meets pready low
  wire take = psel & penable & ~pready;

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= take;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (take && !pwrite) begin
      prdata <= rd_d;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= take & bad_d;
    end
  end

endmodule // ipr_input_remap
`default_nettype wire

// [rtl/ipr_regs.vh]
// Register map, field layout and reset values of the input pin remap selectors
`ifndef IPR_REGS_VH
`define IPR_REGS_VH

`define IPR_ADDR_FAULT_A    12'h000
`define IPR_ADDR_UART_ONE   12'h004
`define IPR_ADDR_UART_TWO   12'h008
`define IPR_ADDR_SPI_ONE_CD 12'h00C
`define IPR_ADDR_SPI_ONE_SS 12'h010
`define IPR_ADDR_SPI_TWO_CD 12'h014
`define IPR_ADDR_SPI_TWO_SS 12'h018
`define IPR_ADDR_LOCK       12'h01C

`define IPR_SEL_W      5
`define IPR_LO_LSB     0
`define IPR_LO_MSB     4
`define IPR_HI_LSB     8
`define IPR_HI_MSB     12
`define IPR_SEL_RESET  5'h1F
`define IPR_SEL_MAXPIN 5'h19
`define IPR_LOCK_BIT   0

`endif

// [tb/ipr_pin_model.sv]
// Remappable pads as seen by the remap unit
`timescale 1ns/1ps
`default_nettype none
module ipr_pin_model #(parameter NUM_PINS = 26) (
  input  wire logic                ref_clk,   // System clock
  input  wire logic [NUM_PINS-1:0] level_set, // Levels asked for
  output var  logic [NUM_PINS-1:0] pin_level  // Pad levels
);
  always @(posedge ref_clk) pin_level <= level_set;
endmodule // ipr_pin_model
`default_nettype wire

// [tb/ipr_remap_assertions.sv]
// Checker of the remap selector ports
`timescale 1ns/1ps
`default_nettype none
module ipr_remap_checker #(parameter NUM_PINS = 26) (
  input wire logic                ref_clk, rst_n, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata, prdata,
  input wire logic [NUM_PINS-1:0] remappable_pin_n,
  input wire logic                remap_write_lock, compare_fault_a_input
);
  logic [4:0] fa_q;
  logic       lk_q, lk2_q, exp_q;
  wire        wr = psel && penable && !pready && pwrite;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      fa_q <= 5'h1F;
      lk_q <= 1'b0;
      lk2_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      if (wr && paddr == 12'h01C) lk_q <= pwdata[0];
      if (wr && paddr == 12'h000 && !lk_q) fa_q <= pwdata[4:0];
      lk2_q <= lk_q;
      exp_q <= fa_q < 5'h1A && remappable_pin_n[fa_q];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take; psel && penable && !pready; endsequence
  sequence s_ans; pready ##1 !pready; endsequence
  AST_ONE_WAIT: assert property (s_take |=> s_ans) else $error("bad wait state");
  AST_ERR_READY: assert property (pslverr |-> pready) else $error("stray error");
  AST_UNMAPPED: assert property ((psel && penable && !pready) && paddr > 12'h01F |=>
    pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  AST_RSVD_ZERO: assert property (pready && !pwrite |-> prdata[31:13] == 19'h0 &&
    prdata[7:5] == 3'h0) else $error("reserved bits set");
  AST_FA_HIGH_ZERO: assert property ((psel && penable && !pready) && !pwrite &&
    paddr == 12'h000 |=>
    prdata[31:5] == 27'h0) else $error("fault a upper bits set");
  AST_RESET_OUT: assert property ($rose(rst_n) |-> !compare_fault_a_input &&
    !remap_write_lock) else $error("outputs not cleared");
  AST_LOCK_COPY: assert property (remap_write_lock == lk2_q) else $error("lock wrong");
  AST_FA_ROUTE: assert property (compare_fault_a_input == exp_q)
    else $error("fault a misrouted");
endmodule // ipr_remap_checker
`default_nettype wire

// [tb/test_input_pin_remap_selectors.sv]
// Self-checking bench of the input pin remap selectors
`timescale 1ns/1ps
`default_nettype none
module test_input_pin_remap_selectors;
  typedef struct {logic [11:0] a; logic [31:0] d, rs, rb;} ipr_row_t;
  logic        ref_clk = 1'b0, rst_n, psel, penable, pwrite, pready, pslverr, remap_write_lock;
  logic        e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [25:0] lvl, pins;
  wire  [10:0] ro;
  int          bad_count = 0, n_compared = 0;
  ipr_row_t rows [7] = '{'{12'h000, 32'hFFFFFF19, 32'h1F, 32'h19},
    '{12'h004, 32'hFFFFE3A2, 32'h1F1F, 32'h0302}, '{12'h008, 32'h0000E4E5, 32'h1F1F, 32'h0405},
    '{12'h00C, 32'h0000F6E7, 32'h1F1F, 32'h1607}, '{12'h010, 32'hFFFFFFE8, 32'h1F, 32'h08},
    '{12'h014, 32'h1234E9EA, 32'h1F1F, 32'h090A}, '{12'h018, 32'h0000FFEB, 32'h1F, 32'h0B}};
  always #5 ref_clk = ~ref_clk;
  ipr_pin_model u_pins (.ref_clk, .level_set(lvl), .pin_level(pins));
  ipr_input_remap u_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .remappable_pin_n(pins), .remap_write_lock,
    .compare_fault_a_input(ro[10]), .uart_one_clear_to_send(ro[9]), .uart_one_receive_in(ro[8]),
    .uart_two_clear_to_send(ro[7]), .uart_two_receive_in(ro[6]), .spi_one_clock_in(ro[5]),
    .spi_one_data_in(ro[4]), .spi_one_slave_select_in(ro[3]), .spi_two_clock_in(ro[2]),
    .spi_two_data_in(ro[1]), .spi_two_slave_select_in(ro[0]));
  function automatic logic [10:0] route(input logic [25:0] p);
    return {p[25], p[3], p[2], p[4], p[5], p[22], p[7], p[8], p[9], p[10], p[11]};
  endfunction
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    for (int n = 0; n < 20 && pready !== 1'b1; n++) @(posedge ref_clk);
    if (pready !== 1'b1) bad_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    end_sim;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rst_n} = '0;
    lvl = '1;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("tied low", ro, 32'h0);
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk("reset value", r, rows[i].rs);
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk("readback", r, rows[i].rb);
    end
    for (int k = 0; k < 2; k++) begin
      lvl <= k ? 26'h2AAAAAA : 26'h1555555;
      repeat (3) @(posedge ref_clk);
      chk("routing", ro, route(lvl));
    end
    $display("table and routing done");
    lvl <= '1;
    for (int c = 26; c < 32; c++) begin
      apb(1'b1, 12'h000, c);
      repeat (3) @(posedge ref_clk);
      chk("fault a low", ro[10], 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk("code readback", r, c);
    end
    apb(1'b1, 12'h01C, 32'h1);
    apb(1'b1, 12'h000, 32'h5);
    apb(1'b0, 12'h000, 32'h0);
    chk("locked write", r, 32'h1F);
    chk("lock flag", remap_write_lock, 32'h1);
    apb(1'b1, 12'h01C, 32'h0);
    apb(1'b1, 12'h000, 32'h5);
    repeat (3) @(posedge ref_clk);
    chk("unlocked route", ro[10], 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", e, 32'h1);
    chk("unmapped data", r, 32'h0);
    $display("lock and refusal done");
    rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("second reset", r, 32'h1F);
    $display("second reset done");
    end_sim;
  end
endmodule // test_input_pin_remap_selectors
bind ipr_input_remap ipr_remap_checker #(.NUM_PINS(NUM_PINS)) u_chk (.ref_clk, .rst_n, .psel,
  .penable, .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .remappable_pin_n,
  .remap_write_lock, .compare_fault_a_input);
`default_nettype wire
